// >>> tb/tcdma_core_assertions.sv
/*
 * tcdma_core_assertions: port-level checks of the transfer controller.
 * assumes: bound to tcdma_core; one clock, synchronous active-high reset.
 */
`timescale 1ns/10ps
module tcdma_core_assertions
  import tcdma_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire tcdma_regreq_s regReq,
  input wire logic [7:0] regRdData,
  input wire logic nmiEvent,
  input wire logic busReq,
  input wire tcdma_bus_s busCmd,
  input wire logic [1:0] memWaitStates,
  input wire logic [1:0] ioWaitStates,
  input wire logic irqReq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_irq_reset: assert property (disable iff (1'b0) sys_rst |=> !irqReq)
    else $error("interrupt high after reset");
  a_wait_reset: assert property (disable iff (1'b0)
    sys_rst |=> memWaitStates == 2'h3 && ioWaitStates == 2'h3)
    else $error("wait fields not ones after reset");
  a_wait_write: assert property (regReq.wr &&
    regReq.addr == OFF_WAIT_REQ_CTRL |=> {memWaitStates, ioWaitStates}
    == $past(regReq.data[7:4])) else $error("wait fields not written");
  a_guard_reads: assert property (regReq.rd &&
    regReq.addr == OFF_STATUS_ENABLE |=> regRdData[5:4] == 2'h3)
    else $error("guard bits read as zero");
  a_nmi_stops: assert property (nmiEvent && !regReq.wr
    |-> ##[1:16] !busReq) else $error("bus still wanted after nmi");
  a_no_io_io: assert property ($fell(busCmd.rd) &&
    $past(busCmd.isIo) |-> !(busCmd.wr && busCmd.isIo))
    else $error("io to io transfer");
  a_read_first: assert property ($rose(busCmd.wr) |-> $past(busCmd.rd))
    else $error("write without preceding read");
  a_mem_len: assert property ($rose(busCmd.rd) && !busCmd.isIo &&
    memWaitStates == 2'h0 |-> busCmd.rd[*3] ##1 !busCmd.rd)
    else $error("memory read length wrong");
  a_io_len: assert property ($rose(busCmd.wr) && busCmd.isIo &&
    ioWaitStates == 2'h1 |-> busCmd.wr[*4] ##1 !busCmd.wr)
    else $error("io write length wrong");

  c_io_write: cover property ($rose(busCmd.wr) && busCmd.isIo);
  c_irq: cover property ($rose(irqReq));
  c_nmi: cover property (nmiEvent && busReq);
endmodule

bind tcdma_core tcdma_core_assertions chk (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .regReq(regReq), .regRdData(regRdData),
  .nmiEvent(nmiEvent), .busReq(busReq), .busCmd(busCmd),
  .memWaitStates(memWaitStates), .ioWaitStates(ioWaitStates),
  .irqReq(irqReq));

// >>> tb/tcdma_periph_model.sv
/*
 * tcdma_periph_model: arbiter plus one byte space serving memory and I/O.
 * assumes: busCmd rd/wr are levels held for the whole access.
 */
`timescale 1ns/10ps
module tcdma_periph_model
  import tcdma_pkg::*;
(
  input wire logic clk_sys,
  input wire logic busReq,
  input wire tcdma_bus_s busCmd,
  input wire logic slow,
  output logic busGrant,
  output logic [7:0] busRdData
);
  logic [7:0] mem [256];
  logic [1:0] cnt = 2'h0;
  logic [7:0] lastQ = 8'h00;
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'ha5;
  // slow mode makes the controller wait three cycles for the bus
  assign busGrant = busReq && (!slow || cnt == 2'h3);
  // released data lines show the inverse of the last byte, never a hold
  assign busRdData = busCmd.rd ? mem[busCmd.addr[7:0]] : ~lastQ;
  always @(posedge clk_sys) begin
    cnt <= busReq ? cnt + {1'b0, cnt != 2'h3} : 2'h0;
    if (busCmd.rd) lastQ <= mem[busCmd.addr[7:0]];
    if (busCmd.wr) mem[busCmd.addr[7:0]] <= busCmd.data;
  end
endmodule

// >>> tb/two_channel_dma_control_test.sv
/*
 * two_channel_dma_control_test: self-checking bench of tcdma_core.
 * assumes: the peripheral model answers the bus; serial requests are
 * driven by the bench.
 */
`timescale 1ns/10ps
module two_channel_dma_control_test
  import tcdma_pkg::*;
;
  logic clk_sys = 0, sys_rst = 1, nmiEvent = 0, slow = 0;
  logic busGrant, busReq, irqReq;
  tcdma_regreq_s regReq = '0;
  tcdma_bus_s busCmd;
  logic [7:0] regRdData, busRdData, rdv;
  logic [1:0] extReq = 2'h0, serialReq = 2'h0, memWaitStates, ioWaitStates;
  logic [31:0] seed = 32'h4c39;
  int n_errors = 0, compares = 0, cyc = 0;

  tcdma_core DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .regReq(regReq),
    .regRdData(regRdData), .nmiEvent(nmiEvent), .extReq(extReq),
    .serialReq(serialReq), .busReq(busReq), .busGrant(busGrant),
    .busCmd(busCmd), .busRdData(busRdData),
    .memWaitStates(memWaitStates), .ioWaitStates(ioWaitStates),
    .irqReq(irqReq));
  tcdma_periph_model periph (.clk_sys(clk_sys), .busReq(busReq),
    .busCmd(busCmd), .slow(slow), .busGrant(busGrant),
    .busRdData(busRdData));

  always #2 clk_sys = ~clk_sys;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] memInit(input logic [7:0] a);
    return a ^ 8'ha5;
  endfunction

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 regReq = '{a, 1'b1, 1'b0, d};
    @(posedge clk_sys);
    #1 regReq.wr = 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    #1 regReq = '{a, 1'b0, 1'b1, 8'h00};
    @(posedge clk_sys);
    #1 regReq.rd = 1'b0;
    rdv = regRdData;
  endtask
  // eight consecutive bytes from base: low address, count low at 6
  task setup(input logic [7:0] base, input logic [7:0] a0,
             input logic [7:0] a3, input logic [7:0] c);
    for (int k = 0; k < 8; k++)
      wr(base + k[7:0], k == 0 ? a0 : k == 3 ? a3 : k == 6 ? c : 8'h00);
  endtask
  task waitClear(input logic [7:0] m);
    for (int i = 0; i < 300; i++) begin
      rd(OFF_STATUS_ENABLE);
      if ((rdv & m) == 8'h00) break;
    end
  endtask
  task finish_test;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test;
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    #1 sys_rst = 0;
    rd(OFF_STATUS_ENABLE); chk(rdv, 8'h30);
    rd(OFF_CH0_MODE); chk(rdv, 8'h00);
    rd(OFF_WAIT_REQ_CTRL); chk(rdv, 8'hf0);
    rd(OFF_CH1_REQ_SELECT); chk(rdv, 8'h00);
    chk({7'h0, irqReq}, 8'h00);
    wr(OFF_STATUS_ENABLE, 8'hf1);
    rd(OFF_STATUS_ENABLE); chk(rdv, 8'h30);
    wr(OFF_STATUS_ENABLE, 8'h01);
    rd(OFF_STATUS_ENABLE); chk(rdv, 8'h30);
    rd(8'h3f); chk(rdv, 8'h00);
    $display("test reset_and_guards done");
    // every mode code once, other bits random
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(OFF_CH0_MODE, {seed[7:6], i[1:0], i[1:0], seed[1:0]});
      rd(OFF_CH0_MODE); chk(rdv, {2'h0, i[1:0], i[1:0], seed[1], 1'b0});
      wr(OFF_WAIT_REQ_CTRL, {seed[15:10], i[1:0]});
      rd(OFF_WAIT_REQ_CTRL); chk(rdv, {seed[15:10], i[1:0]});
      chk({4'h0, memWaitStates, ioWaitStates}, {4'h0, seed[15:12]});
      wr(OFF_CH1_REQ_SELECT, seed[23:16]);
      rd(OFF_CH1_REQ_SELECT); chk(rdv, seed[23:16]);
      wr(OFF_CH1_IO_HIGH, seed[31:24]);
      rd(OFF_CH1_IO_HIGH); chk(rdv, seed[31:24]);
    end
    $display("test mode_fields done");
    setup(OFF_SRC0_ADDR, 8'h10, 8'h80, 8'h03);
    wr(OFF_CH0_MODE, 8'h00);
    wr(OFF_WAIT_REQ_CTRL, 8'h00);
    wr(OFF_STATUS_ENABLE, 8'h64);
    waitClear(8'h40); chk(rdv, 8'h35);
    chk({7'h0, irqReq}, 8'h01);
    for (int i = 0; i < 3; i++)
      chk(periph.mem[8'h80 + i], memInit(8'h10 + i[7:0]));
    rd(OFF_CH0_COUNT); chk(rdv, 8'h00);
    wr(OFF_STATUS_ENABLE, 8'h30);
    chk({7'h0, irqReq}, 8'h00);
    $display("test steal_copy done");
    slow = 1;
    setup(OFF_SRC0_ADDR, 8'h20, 8'h90, 8'h02);
    wr(OFF_CH0_MODE, 8'h02);
    wr(OFF_STATUS_ENABLE, 8'h64);
    nmiEvent = 1;
    @(posedge clk_sys);
    #1 nmiEvent = 0;
    rd(OFF_STATUS_ENABLE); chk(rdv, 8'h74);
    rd(OFF_CH0_COUNT); chk(rdv, 8'h02);
    wr(OFF_STATUS_ENABLE, 8'h64);
    waitClear(8'h40); chk(rdv, 8'h35);
    for (int i = 0; i < 2; i++)
      chk(periph.mem[8'h90 + i], memInit(8'h20 + i[7:0]));
    slow = 0;
    $display("test nmi_burst done");
    // channel 0 reads an I/O port paced by the pin, channel 1 by serial 0
    setup(OFF_SRC0_ADDR, 8'h33, 8'ha0, 8'h01);
    wr(OFF_CH0_MODE, 8'h0c);
    setup(OFF_CH1_MEM_ADDR, 8'h40, 8'h05, 8'h01);
    wr(OFF_CH1_REQ_SELECT, 8'h01);
    wr(OFF_WAIT_REQ_CTRL, 8'h14);
    wr(OFF_STATUS_ENABLE, 8'hc8);
    repeat (8) @(posedge clk_sys);
    chk(periph.mem[8'h05], memInit(8'h05));
    chk(periph.mem[8'ha0], memInit(8'ha0));
    #1 extReq = 2'h1;
    serialReq = 2'h1;
    waitClear(8'hc0); chk(rdv, 8'h39);
    extReq = 2'h0;
    serialReq = 2'h0;
    chk(periph.mem[8'h05], memInit(8'h40));
    chk(periph.mem[8'ha0], memInit(8'h33));
    chk({7'h0, irqReq}, 8'h01);
    $display("test chan1_io done");
    finish_test;
  end
endmodule

// >>> verilog/tcdma_core.sv
/*
 * tcdma_core: enables, modes, counters and transfer engine of a
 * two-channel transfer controller with its processor I/O registers.
 * assumes: a processor I/O strobe port on clk_sys, a system bus arbiter
 * answering busReq with busGrant, and peripherals that return read data
 * at the last cycle of a bus access.
 */
// How it works
// - a channel runs only with its own enable and the main enable set
// - count reaching zero clears that channel's enable by hardware
// - enable low with its interrupt enable high raises the interrupt
// - software changes an enable only when its guard bit is written 0
// - both guard bits always read back as one
// - a permitted write of one to an enable also sets main enable
// - writing an enable to zero pauses; address and count are kept
// - a nonmaskable interrupt clears the main enable
// - main enable is not writable; rewriting an enable with one resumes
// - reset clears enables, interrupt enables and main enable
// - channel 0 destination: inc, dec, fixed memory, or fixed I/O
// - channel 0 source uses the same four-way coding
// - channel 0 never runs I/O to I/O
// - memory copy timing bit: one burst, zero cycle steal
// - burst holds the bus to the end; steal yields a cycle per byte
// - with an I/O end, the request paces bytes and timing is ignored
// - memory wait field sets memory wait states, resets to ones
// - I/O wait field sets I/O wait states, resets to ones
// - sense bits per channel: zero level, one edge, reset zero
// - channel 1 mode: direction and memory step; I/O address fixed
// - channel 1 I/O address of 16 bits; the request select register picks the request
// - each transferred byte decrements the 16-bit count by one
`timescale 1ns/10ps
module tcdma_core
  import tcdma_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire tcdma_regreq_s regReq,
  output logic [7:0] regRdData,
  input wire logic nmiEvent,
  input wire logic [1:0] extReq,
  input wire logic [1:0] serialReq,
  output logic busReq,
  input wire logic busGrant,
  output tcdma_bus_s busCmd,
  input wire logic [7:0] busRdData,
  output logic [1:0] memWaitStates,
  output logic [1:0] ioWaitStates,
  output logic irqReq
);

  // ************************************************************
  // register state
  // ************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_GAP} tcdma_st_e;

  logic [1:0] chEn_q;
  logic [1:0] chEn_d;
  logic [1:0] irqEn_q;
  logic mainEn_q;
  logic [7:0] mode0_q;
  logic [7:0] ctrl_q;
  logic [7:0] reqSel1_q;
  logic [15:0] io1_q;
  logic [19:0] src0_q;
  logic [19:0] dst0_q;
  logic [19:0] mem1_q;
  logic [1:0][15:0] cnt_q;
  tcdma_st_e state_q;
  tcdma_st_e state_d;
  logic act_q;
  logic [2:0] cyc_q;

  function automatic logic [19:0] putByte(input logic [19:0] cur,
                                          input logic [1:0] lane,
                                          input logic [7:0] d);
    logic [19:0] r;
    r = cur;
    case (lane)
      2'h0: r[7:0] = d;
      2'h1: r[15:8] = d;
      default: r[19:16] = d[3:0];
    endcase
    return r;
  endfunction

  function automatic logic [19:0] stepAddr(input logic [19:0] a,
                                           input logic [1:0] m);
    case (m)
      2'h0: return a + 20'h1;
      2'h1: return a - 20'h1;
      default: return a;
    endcase
  endfunction

  // ************************************************************
  // register decode
  // ************************************************************
  wire [7:0] wd = regReq.data;
  wire [7:0] ra = regReq.addr;
  wire wrStat = regReq.wr && ra == OFF_STATUS_ENABLE;
  wire wrMode0 = regReq.wr && ra == OFF_CH0_MODE;
  wire wrCtrl = regReq.wr && ra == OFF_WAIT_REQ_CTRL;
  wire wrReqSel = regReq.wr && ra == OFF_CH1_REQ_SELECT;
  wire wrIoLow = regReq.wr && ra == OFF_CH1_IO_LOW;
  wire wrIoHigh = regReq.wr && ra == OFF_CH1_IO_HIGH;
  wire [7:0] offSrc = ra - OFF_SRC0_ADDR;
  wire [7:0] offDst = ra - OFF_DST0_ADDR;
  wire [7:0] offMem = ra - OFF_CH1_MEM_ADDR;
  wire [7:0] offC0 = ra - OFF_CH0_COUNT;
  wire [7:0] offC1 = ra - OFF_CH1_COUNT;
  wire wrSrc = regReq.wr && offSrc < 8'h3;
  wire wrDst = regReq.wr && offDst < 8'h3;
  wire wrMem = regReq.wr && offMem < 8'h3;
  wire [1:0] wrCnt = {regReq.wr && offC1 < 8'h2,
                      regReq.wr && offC0 < 8'h2};
  wire [1:0][0:0] cntLane = {offC1[0], offC0[0]};

  wire [7:0] statRead = {chEn_q, 2'b11, irqEn_q, 1'b0, mainEn_q};
  logic [7:0] rdMux;

  always_comb begin
    case (ra)
      OFF_STATUS_ENABLE: rdMux = statRead;
      OFF_CH0_MODE: rdMux = mode0_q;
      OFF_WAIT_REQ_CTRL: rdMux = ctrl_q;
      OFF_CH1_IO_LOW: rdMux = io1_q[7:0];
      OFF_CH1_IO_HIGH: rdMux = io1_q[15:8];
      OFF_CH1_REQ_SELECT: rdMux = reqSel1_q;
      8'h20: rdMux = src0_q[7:0];
      8'h21: rdMux = src0_q[15:8];
      8'h22: rdMux = {4'h0, src0_q[19:16]};
      8'h23: rdMux = dst0_q[7:0];
      8'h24: rdMux = dst0_q[15:8];
      8'h25: rdMux = {4'h0, dst0_q[19:16]};
      8'h26: rdMux = cnt_q[0][7:0];
      8'h27: rdMux = cnt_q[0][15:8];
      8'h28: rdMux = mem1_q[7:0];
      8'h29: rdMux = mem1_q[15:8];
      8'h2a: rdMux = {4'h0, mem1_q[19:16]};
      8'h2e: rdMux = cnt_q[1][7:0];
      8'h2f: rdMux = cnt_q[1][15:8];
      default: rdMux = 8'h00;
    endcase
  end

  // ************************************************************
  // mode fields
  // ************************************************************
  wire [1:0] dstMode = mode0_q[POS_DEST_MODE +: 2];
  wire [1:0] srcMode = mode0_q[POS_SRC_MODE +: 2];
  wire burst = mode0_q[POS_MEM_COPY_TIMING];
  wire [1:0] ch1Mode = ctrl_q[POS_CH1_MODE +: 2];
  wire ch1IoToMem = ch1Mode[1];
  wire [1:0] ch1MemStep = {1'b0, ch1Mode[0]};
  wire srcIo = srcMode == MODE_IO_FIXED;
  wire dstIo = dstMode == MODE_IO_FIXED;
  wire ioToIo = srcIo && dstIo;
  wire ch0Paced = srcIo || dstIo;

  assign memWaitStates = ctrl_q[POS_MEM_WAIT +: 2];
  assign ioWaitStates = ctrl_q[POS_IO_WAIT +: 2];

  // ************************************************************
  // request sensing
  // ************************************************************
  // an I/O end's upper address bits pick channel 0's request source
  wire [1:0] ch0Sel = srcIo ? src0_q[17:16] : dst0_q[17:16];
  wire [1:0][1:0] reqSel = {reqSel1_q[1:0], ch0Sel};
  wire [1:0] senseEdge = {ctrl_q[POS_CH1_SENSE],
                          ctrl_q[POS_CH0_SENSE]};
  logic [1:0] reqActive;
  logic [1:0] consume;

  for (genvar i = 0; i < 2; i++) begin : g_sense
    tcdma_req_sense u_sense (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .extReq(extReq[i]),
      .serialReq(serialReq),
      .srcSel(reqSel[i]),
      .edgeMode(senseEdge[i]),
      .consume(consume[i]),
      .reqActive(reqActive[i])
    );
  end

  // ************************************************************
  // channel selection and bus addresses
  // ************************************************************
  wire ch0Ready = chEn_q[0] && mainEn_q && !ioToIo &&
                  (!ch0Paced || reqActive[0]);
  wire ch1Ready = chEn_q[1] && mainEn_q && reqActive[1];
  wire pick = !ch0Ready;
  wire anyReady = ch0Ready || ch1Ready;

  logic fifoInReady;
  logic fifoOutValid;
  logic [7:0] fifoOutData;

  wire start = state_q == ST_IDLE && anyReady && busGrant && fifoInReady;

  wire rdIo = act_q ? !ch1IoToMem : srcIo;
  wire wrIo = act_q ? ch1IoToMem : dstIo;
  wire [19:0] io1Addr = {4'h0, io1_q};
  wire [19:0] rdAddr = act_q ? (ch1IoToMem ? io1Addr : mem1_q) : src0_q;
  wire [19:0] wrAddr = act_q ? (ch1IoToMem ? mem1_q : io1Addr) : dst0_q;
  wire [2:0] rdLen = BUS_BASE_CYCLES +
                     {1'b0, rdIo ? ioWaitStates : memWaitStates};
  wire [2:0] wrLen = BUS_BASE_CYCLES +
                     {1'b0, wrIo ? ioWaitStates : memWaitStates};
  wire [2:0] startLen = BUS_BASE_CYCLES + {1'b0, (pick ?
                        !ch1IoToMem : srcIo) ? ioWaitStates : memWaitStates};

  wire cycDone = cyc_q == 3'h0;
  wire pushByte = state_q == ST_READ && cycDone && fifoInReady;
  wire byteDone = state_q == ST_WRITE && cycDone && fifoOutValid;
  wire lastByte = cnt_q[act_q] == 16'h0001;
  wire [1:0] termHit = {2{byteDone && lastByte}} &
                       {act_q, !act_q};
  // burst runs on only while the channel is still fully enabled
  wire keepBus = !act_q && !ch0Paced && burst && chEn_d[0] &&
                 mainEn_q && !nmiEvent;

  assign consume = {2{start}} & {pick, !pick};

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (start) begin
        state_d = ST_READ;
      end
      ST_READ: if (pushByte) begin
        state_d = ST_WRITE;
      end
      ST_WRITE: if (byteDone) begin
        if (keepBus) begin
          state_d = ST_READ;
        end else if (!act_q && !ch0Paced) begin
          state_d = ST_GAP;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_GAP: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  assign busReq = (state_q == ST_READ) || (state_q == ST_WRITE) ||
                  (state_q == ST_IDLE && anyReady && fifoInReady);
  assign busCmd = '{
    addr: state_q == ST_WRITE ? wrAddr : rdAddr,
    isIo: state_q == ST_WRITE ? wrIo : rdIo,
    rd: state_q == ST_READ,
    wr: state_q == ST_WRITE,
    data: fifoOutData
  };

  tcdma_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .inValid(pushByte),
    .inReady(fifoInReady),
    .inData(busRdData),
    .outValid(fifoOutValid),
    .outReady(byteDone),
    .outData(fifoOutData)
  );

  // ************************************************************
  // enable logic
  // ************************************************************
  logic [1:0] swSet;

  for (genvar i = 0; i < 2; i++) begin : g_enable
    wire permit = wrStat && !wd[POS_CH0_GUARD + i];
    assign chEn_d[i] = permit ? wd[POS_CH0_ENABLE + i] :
                       (termHit[i] ? 1'b0 : chEn_q[i]);
    assign swSet[i] = permit && wd[POS_CH0_ENABLE + i];
  end

  assign irqReq = |(~chEn_q & irqEn_q);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      chEn_q <= 2'b00;
      irqEn_q <= 2'b00;
      mainEn_q <= 1'b0;
    end else begin
      chEn_q <= chEn_d;
      if (wrStat) begin
        irqEn_q <= wd[POS_CH0_IRQ_ENABLE +: 2];
      end
      // main enable has no direct write; a resuming write beats an nmi
      if (|swSet) begin
        mainEn_q <= 1'b1;
      end else if (nmiEvent) begin
        mainEn_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // mode and control registers
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode0_q <= RST_CH0_MODE;
      ctrl_q <= RST_WAIT_REQ_CTRL;
      reqSel1_q <= RST_CH1_REQ_SELECT;
      io1_q <= 16'h0000;
    end else begin
      if (wrMode0) begin
        mode0_q <= {2'b00, wd[5:1], 1'b0};
      end
      if (wrCtrl) begin
        ctrl_q <= wd;
      end
      if (wrReqSel) begin
        reqSel1_q <= wd;
      end
      if (wrIoLow) begin
        io1_q[7:0] <= wd;
      end
      if (wrIoHigh) begin
        io1_q[15:8] <= wd;
      end
    end
  end

  // ************************************************************
  // address and count registers
  // ************************************************************
  // software writes land after the engine's step so they win
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      src0_q <= RST_ADDR;
      dst0_q <= RST_ADDR;
      mem1_q <= RST_ADDR;
      cnt_q <= {RST_COUNT, RST_COUNT};
    end else begin
      if (byteDone) begin
        cnt_q[act_q] <= cnt_q[act_q] - 16'h0001;
        if (act_q) begin
          mem1_q <= stepAddr(mem1_q, ch1MemStep);
        end else begin
          src0_q <= stepAddr(src0_q, srcMode);
          dst0_q <= stepAddr(dst0_q, dstMode);
        end
      end
      if (wrSrc) begin
        src0_q <= putByte(src0_q, offSrc[1:0], wd);
      end
      if (wrDst) begin
        dst0_q <= putByte(dst0_q, offDst[1:0], wd);
      end
      if (wrMem) begin
        mem1_q <= putByte(mem1_q, offMem[1:0], wd);
      end
      for (int c = 0; c < 2; c++) begin
        if (wrCnt[c]) begin
          cnt_q[c][cntLane[c] * 8 +: 8] <= wd;
        end
      end
    end
  end

  // ************************************************************
  // engine sequencing
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      act_q <= 1'b0;
      cyc_q <= 3'h0;
      regRdData <= 8'h00;
    end else begin
      state_q <= state_d;
      if (start) begin
        act_q <= pick;
        cyc_q <= startLen - 3'h1;
      end else if (pushByte) begin
        cyc_q <= wrLen - 3'h1;
      end else if (byteDone && keepBus) begin
        cyc_q <= rdLen - 3'h1;
      end else if (!cycDone) begin
        cyc_q <= cyc_q - 3'h1;
      end
      if (regReq.rd) begin
        regRdData <= rdMux;
      end
    end
  end
endmodule

// >>> verilog/tcdma_fifo.sv
/*
 * tcdma_fifo: synchronous byte buffer between the read and write halves
 * of each transfer.
 * assumes: one clock; producer and consumer obey valid/ready.
 */
`timescale 1ns/10ps
module tcdma_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_q;
  logic [AW:0] rdPtr_q;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  // extra pointer bit tells full from empty
  assign inReady = (wrPtr_q ^ rdPtr_q) != {1'b1, {AW{1'b0}}};
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData = mem[rdPtr_q[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule

// >>> verilog/tcdma_pkg.sv
/*
 * tcdma_pkg: register offsets, field positions, reset values and shared
 * types of the two-channel transfer controller.
 * assumes: an 8-bit processor I/O register space and a 20-bit memory bus.
 */
package tcdma_pkg;

  // ************************************************************
  // register offsets (processor I/O space)
  // ************************************************************
  localparam logic [7:0] OFF_SRC0_ADDR = 8'h20;
  localparam logic [7:0] OFF_DST0_ADDR = 8'h23;
  localparam logic [7:0] OFF_CH0_COUNT = 8'h26;
  localparam logic [7:0] OFF_CH1_MEM_ADDR = 8'h28;
  localparam logic [7:0] OFF_CH1_IO_LOW = 8'h2b;
  localparam logic [7:0] OFF_CH1_IO_HIGH = 8'h2c;
  localparam logic [7:0] OFF_CH1_REQ_SELECT = 8'h2d;
  localparam logic [7:0] OFF_CH1_COUNT = 8'h2e;
  localparam logic [7:0] OFF_STATUS_ENABLE = 8'h30;
  localparam logic [7:0] OFF_CH0_MODE = 8'h31;
  localparam logic [7:0] OFF_WAIT_REQ_CTRL = 8'h32;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int POS_CH0_ENABLE = 6;
  localparam int POS_CH0_GUARD = 4;
  localparam int POS_CH0_IRQ_ENABLE = 2;
  localparam int POS_MAIN_ENABLE = 0;
  localparam int POS_DEST_MODE = 4;
  localparam int POS_SRC_MODE = 2;
  localparam int POS_MEM_COPY_TIMING = 1;
  localparam int POS_MEM_WAIT = 6;
  localparam int POS_IO_WAIT = 4;
  localparam int POS_CH0_SENSE = 3;
  localparam int POS_CH1_SENSE = 2;
  localparam int POS_CH1_MODE = 0;

  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam logic [7:0] RST_CH0_MODE = 8'h00;
  localparam logic [7:0] RST_WAIT_REQ_CTRL = 8'hf0;
  localparam logic [7:0] RST_CH1_REQ_SELECT = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [19:0] RST_ADDR = 20'h00000;
  localparam logic [2:0] BUS_BASE_CYCLES = 3'h3;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_MEM_INC,
    MODE_MEM_DEC,
    MODE_MEM_FIXED,
    MODE_IO_FIXED
  } tcdma_mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] data;
  } tcdma_regreq_s;

  typedef struct packed {
    logic [19:0] addr;
    logic isIo;
    logic rd;
    logic wr;
    logic [7:0] data;
  } tcdma_bus_s;

endpackage

// >>> verilog/tcdma_req_sense.sv
/*
 * tcdma_req_sense: picks one channel's request source and senses it by
 * level or by rising edge.
 * assumes: extReq is an asynchronous pin; serialReq comes from logic on
 * clk_sys.
 */
`timescale 1ns/10ps
module tcdma_req_sense (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic extReq,
  input wire logic [1:0] serialReq,
  input wire logic [1:0] srcSel,
  input wire logic edgeMode,
  input wire logic consume,
  output logic reqActive
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic pending_q;
  logic raw;

  always_comb begin
    case (srcSel)
      2'h0: raw = sync2_q;
      2'h1: raw = serialReq[0];
      2'h2: raw = serialReq[1];
      default: raw = 1'b0;
    endcase
  end

  wire rise = raw && !prev_q;

  assign reqActive = edgeMode ? pending_q : raw;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      pending_q <= 1'b0;
    end else begin
      sync1_q <= extReq;
      sync2_q <= sync1_q;
      prev_q <= raw;
      // a new edge in the consuming cycle stays pending
      pending_q <= rise || (pending_q && !consume);
    end
  end
endmodule
